// >>> rtl/usb_phy_ctrl_pkg.sv
// Purpose: Shared constants for the endpoint mark and PHY line-control block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses as listed
// Notes:   Register layouts, line-state codes and interrupt bits
package usb_phy_ctrl_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam logic [7:0]  OFS_EP_MARK       = 8'h34;
  localparam logic [7:0]  OFS_OTG_MASK      = 8'h38;
  localparam logic [7:0]  OFS_PWR_WORD      = 8'h3c;
  localparam logic [7:0]  OFS_PHY_CTRL      = 8'h40;
  localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h44;
  localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'h48;
  localparam logic [7:0]  OFS_IRQ_ENABLE    = 8'h4c;
  localparam logic [7:0]  OFS_LINE_STATUS   = 8'h50;
  localparam int          NUM_EP            = 16;
  localparam logic [4:0]  EP_MARK_OR        = 5'h10;
  localparam int          PWR_W             = 9;
  localparam int          BIT_PD_DIS        = 18;
  localparam int          BIT_RST_CAUSE     = 13;
  localparam int          BIT_RES_CAUSE     = 12;
  localparam int          FILT_LO           = 8;
  localparam int          FILT_HI           = 11;
  localparam int          BIT_SUSP_EN       = 7;
  localparam int          CONF_LO           = 4;
  localparam int          CONF_HI           = 6;
  localparam logic [31:0] PHY_CTRL_WMASK    = 32'h0004_3ff0;
  localparam logic [1:0]  LS_SE0            = 2'h0;
  localparam logic [1:0]  LS_J              = 2'h1;
  localparam logic [1:0]  LS_K              = 2'h2;
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_LS_CHANGE     = 0;
  localparam int          IRQ_RST_RESUME    = 1;
  localparam int          IRQ_K_RESUME      = 2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  localparam int          FILT_CNT_W        = 16;
endpackage

// >>> rtl/line_filt_if.sv
// Purpose: Carries raw and filtered line state between the top and the filter
// Assumes: One clock domain
// Notes:   Top drives raw state and the length code
interface line_filt_if;
  logic [1:0] raw_ls;    // Unfiltered line state
  logic [3:0] log2_len;  // Filter length code
  logic [1:0] filt_ls;   // Filtered line state
  logic       change;    // One-cycle pulse on a filtered change
  modport top  (output raw_ls, output log2_len, input filt_ls, input change);
  modport filt (input raw_ls, input log2_len, output filt_ls, output change);
endinterface

// >>> rtl/line_state_filter.sv
// Purpose: Holds back line-state changes for two to the power of the code
// Assumes: Raw line state synchronous to clk_sys
// Notes:   A candidate that moves restarts the count, so glitches vanish
module line_state_filter
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic  clk_sys,  // System clock
  input  wire logic  rst,      // Async reset, active high
  line_filt_if.filt  lf        // Line-state filter link
);
  logic [1:0]            cand_r;
  logic [FILT_CNT_W-1:0] cnt_r;
  logic [1:0]            filt_r;
  logic                  chg_r;
  logic [FILT_CNT_W-1:0] len;

  // Interval length in clocks; code above 15 cannot occur with four bits
  assign len = FILT_CNT_W'(1) << lf.log2_len;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Start at the idle J level, so leaving reset is not a line change
      cand_r <= LS_J;
      cnt_r  <= '0;
      filt_r <= LS_J;
      chg_r  <= 1'b0;
    end else begin
      chg_r <= 1'b0;
      if (lf.raw_ls != cand_r) begin
        cand_r <= lf.raw_ls;
        cnt_r  <= FILT_CNT_W'(1);
      end else if (cand_r != filt_r) begin
        if (cnt_r >= len) begin
          filt_r <= cand_r;
          chg_r  <= 1'b1;
        end else begin
          cnt_r <= cnt_r + FILT_CNT_W'(1);
        end
      end
    end
  end

  assign lf.filt_ls = filt_r;
  assign lf.change  = chg_r;

  a_filt_hold_glitch: assert property (@(posedge clk_sys) disable iff (rst)
    (lf.raw_ls != cand_r) |=> $stable(filt_r))
    else $error("filtered state moved on a raw change");
  a_filt_full_count: assert property (@(posedge clk_sys) disable iff (rst)
    (filt_r != $past(filt_r)) |-> ($past(cnt_r) >= $past(len)))
    else $error("filtered state moved before the interval ended");
endmodule

// >>> rtl/usb_ep_phy_ctrl.sv
// Purpose: Endpoint marks, OTG mask, power word and PHY line control over AXI4-Lite
// Assumes: One clock, UTMI+ line state synchronous to clk_sys
// Notes:   Status events interrupt through an enable register
//
// Added by the designer: the AXI4-Lite slave port.
module usb_ep_phy_ctrl
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic                            clk_sys,        // System clock 20 MHz
  input  wire logic                            rst,            // Async reset, active high
  input  wire logic [usb_phy_ctrl_pkg::ADDR_W-1:0] s_awaddr,   // Write address
  input  wire logic                            s_awvalid,      // Write address valid
  output logic                                 s_awready,      // Write address ready
  input  wire logic [31:0]                     s_wdata,        // Write data
  input  wire logic [3:0]                      s_wstrb,        // Write byte strobes
  input  wire logic                            s_wvalid,       // Write data valid
  output logic                                 s_wready,       // Write data ready
  output logic [1:0]                           s_bresp,        // Write response
  output logic                                 s_bvalid,       // Write response valid
  input  wire logic                            s_bready,       // Write response ready
  input  wire logic [usb_phy_ctrl_pkg::ADDR_W-1:0] s_araddr,   // Read address
  input  wire logic                            s_arvalid,      // Read address valid
  output logic                                 s_arready,      // Read address ready
  output logic [31:0]                          s_rdata,        // Read data
  output logic [1:0]                           s_rresp,        // Read response
  output logic                                 s_rvalid,       // Read data valid
  input  wire logic                            s_rready,       // Read data ready
  input  wire logic [3:0]                      rx_ep_in,       // Endpoint from token decoder
  output logic [4:0]                           rx_ep_out,      // Endpoint on receive port
  input  wire logic [1:0]                      utmi_linestate, // Raw UTMI+ line state
  input  wire logic                            suspended,      // Link in suspend
  output logic                                 resume_req,     // Resume seen by suspend ctrl
  output logic                                 pd_off_8a,      // Pulldown off, port 8A
  output logic                                 pd_off_8b,      // Pulldown off, port 8B
  output logic [2:0]                           phy_config_pins,// PHY configuration pins
  output logic [31:0]                          otg_mask_out,   // OTG flag mask value
  output logic [8:0]                           pwr_word_out,   // Power signalling word
  output logic                                 irq             // Level interrupt
);
  import usb_phy_ctrl_pkg::*;

  logic [NUM_EP-1:0] ep_mark_r;
  logic [31:0]       otg_mask_r;
  logic [PWR_W-1:0]  pwr_r;
  logic [31:0]       phy_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_en_r;
  logic [4:0]        ep_out_r;
  logic              resume_r;
  logic              pd_r;
  logic [2:0]        conf_r;
  logic              irq_r;
  logic              aw_got_r, w_got_r;
  logic              aw_rdy_r, w_rdy_r, ar_rdy_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic              wr_go;
  logic [31:0]       wmask;
  logic              rst_resume, k_resume;
  logic [IRQ_W-1:0]  irq_evt;

  line_filt_if lf ();

  // Raw state and length code go to the filter
  assign lf.raw_ls   = utmi_linestate;
  assign lf.log2_len = phy_r[FILT_HI:FILT_LO];

  line_state_filter u_filt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .lf      (lf)
  );

  // controller handles resume
  // Resume is taken from the filtered state only, so line glitches cannot wake the link
  assign rst_resume = phy_r[BIT_SUSP_EN] && suspended && lf.change && (lf.filt_ls == LS_SE0);
  assign k_resume   = phy_r[BIT_SUSP_EN] && suspended && lf.change && (lf.filt_ls == LS_K);

  // Write happens once both address and data are held and the response slot is free
  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // AXI write address and data capture, either order
  // Ready has its own flop, the inverse of the held flag, so no bus output
  // passes through a gate; the cost is two extra flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_rdy_r  <= 1'b1;
      w_rdy_r   <= 1'b1;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (s_awvalid && !aw_got_r) begin
        aw_got_r  <= 1'b1;
        aw_rdy_r  <= 1'b0;
        aw_addr_r <= s_awaddr;
      end
      if (s_wvalid && !w_got_r) begin
        w_got_r  <= 1'b1;
        w_rdy_r  <= 1'b0;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r  <= 1'b1;
      end
    end
  end

  assign s_awready = aw_rdy_r;
  assign s_wready  = w_rdy_r;

  // Write response, unmapped addresses answer SLVERR
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      unique case (aw_addr_r)
        OFS_EP_MARK, OFS_OTG_MASK, OFS_PWR_WORD, OFS_PHY_CTRL,
        OFS_IRQ_CLEAR, OFS_IRQ_ENABLE, OFS_IRQ_STATUS, OFS_LINE_STATUS: bresp_r <= RESP_OKAY;
        default: bresp_r <= RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_r;
  assign s_bresp  = bresp_r;

  // Plain read-write registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ep_mark_r  <= '0;
      otg_mask_r <= '0;
      pwr_r      <= '0;
      irq_en_r   <= '0;
    end else if (wr_go) begin
      if (aw_addr_r == OFS_EP_MARK) begin
        ep_mark_r <= (ep_mark_r & ~wmask[NUM_EP-1:0]) | (w_data_r[NUM_EP-1:0] & wmask[NUM_EP-1:0]);
      end
      if (aw_addr_r == OFS_OTG_MASK) begin
        otg_mask_r <= (otg_mask_r & ~wmask) | (w_data_r & wmask);
      end
      if (aw_addr_r == OFS_PWR_WORD) begin
        pwr_r <= (pwr_r & ~wmask[PWR_W-1:0]) | (w_data_r[PWR_W-1:0] & wmask[PWR_W-1:0]);
      end
      if (aw_addr_r == OFS_IRQ_ENABLE) begin
        irq_en_r <= (irq_en_r & ~wmask[IRQ_W-1:0]) | (w_data_r[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
      end
    end
  end

  // PHY control; cause flags set by hardware win over a software clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phy_r <= '0;
    end else begin
      if (wr_go && aw_addr_r == OFS_PHY_CTRL) begin
        phy_r <= (phy_r & ~(wmask & PHY_CTRL_WMASK)) | (w_data_r & wmask & PHY_CTRL_WMASK);
      end
      if (rst_resume) begin
        phy_r[BIT_RST_CAUSE] <= 1'b1;
      end
      if (k_resume) begin
        phy_r[BIT_RES_CAUSE] <= 1'b1;
      end
    end
  end

  // Sticky interrupt events; write-one-to-clear, set wins
  assign irq_evt = {k_resume, rst_resume, lf.change};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (wr_go && aw_addr_r == OFS_IRQ_CLEAR && w_strb_r[0]) begin
      irq_stat_r <= (irq_stat_r & ~w_data_r[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Registered outputs toward PHY and receive port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ep_out_r <= '0;
      resume_r <= 1'b0;
      pd_r     <= 1'b0;
      conf_r   <= '0;
      irq_r    <= 1'b0;
    end else begin
      ep_out_r <= ep_mark_r[rx_ep_in] ? ({1'b0, rx_ep_in} | EP_MARK_OR) : {1'b0, rx_ep_in};
      resume_r <= rst_resume || k_resume;
      pd_r     <= phy_r[BIT_PD_DIS];
      conf_r   <= phy_r[CONF_HI:CONF_LO];
      irq_r    <= |(irq_stat_r & irq_en_r);
    end
  end

  assign rx_ep_out       = ep_out_r;
  assign resume_req      = resume_r;
  assign pd_off_8a       = pd_r;
  assign pd_off_8b       = pd_r;
  assign phy_config_pins = conf_r;
  assign otg_mask_out    = otg_mask_r;
  assign pwr_word_out    = pwr_r;
  assign irq             = irq_r;

  // AXI read: one cycle from address to data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      ar_rdy_r <= 1'b1;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (s_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      ar_rdy_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      unique case (s_araddr)
        OFS_EP_MARK:     rdata_r <= 32'(ep_mark_r);
        OFS_OTG_MASK:    rdata_r <= otg_mask_r;
        OFS_PWR_WORD:    rdata_r <= 32'(pwr_r);
        OFS_PHY_CTRL:    rdata_r <= phy_r;
        OFS_IRQ_STATUS:  rdata_r <= 32'(irq_stat_r);
        OFS_IRQ_ENABLE:  rdata_r <= 32'(irq_en_r);
        OFS_IRQ_CLEAR:   rdata_r <= '0;
        OFS_LINE_STATUS: rdata_r <= 32'(lf.filt_ls);
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_rready) begin
      rvalid_r <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end

  assign s_arready = ar_rdy_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;

  a_ep_mark_or: assert property (@(posedge clk_sys) disable iff (rst)
    ep_mark_r[rx_ep_in] |=> (rx_ep_out == ({1'b0, $past(rx_ep_in)} | EP_MARK_OR)))
    else $error("marked endpoint not ORed with 0x10");

  a_ep_unmarked: assert property (@(posedge clk_sys) disable iff (rst)
    !ep_mark_r[rx_ep_in] |=> (rx_ep_out == {1'b0, $past(rx_ep_in)}))
    else $error("unmarked endpoint altered");

  a_pd_follow: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (pd_off_8a == $past(phy_r[BIT_PD_DIS])) && (pd_off_8b == pd_off_8a))
    else $error("pulldown outputs do not follow bit 18");

  a_rst_cause_set: assert property (@(posedge clk_sys) disable iff (rst)
    rst_resume |=> phy_r[BIT_RST_CAUSE])
    else $error("reset-cause flag not set");

  a_rst_cause_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (phy_r[BIT_RST_CAUSE] && !(wr_go && aw_addr_r == OFS_PHY_CTRL)) |=> phy_r[BIT_RST_CAUSE])
    else $error("reset-cause flag dropped without write");

  a_rst_cause_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && aw_addr_r == OFS_PHY_CTRL && w_strb_r[1] && !w_data_r[BIT_RST_CAUSE]
     && !rst_resume) |=> !phy_r[BIT_RST_CAUSE])
    else $error("reset-cause flag not cleared by a zero write");

  a_k_cause_set: assert property (@(posedge clk_sys) disable iff (rst)
    k_resume |=> phy_r[BIT_RES_CAUSE])
    else $error("resume-cause flag not set");

  a_k_cause_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (phy_r[BIT_RES_CAUSE] && !(wr_go && aw_addr_r == OFS_PHY_CTRL)) |=> phy_r[BIT_RES_CAUSE])
    else $error("resume-cause flag dropped without write");

  a_susp_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !phy_r[BIT_SUSP_EN] |=> !resume_req)
    else $error("resume raised with suspend handling off");

  a_resume_cause: assert property (@(posedge clk_sys) disable iff (rst)
    resume_req |-> $past(phy_r[BIT_SUSP_EN] && suspended))
    else $error("resume raised outside suspend");

  a_conf_pins: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 phy_config_pins == $past(phy_r[CONF_HI:CONF_LO]))
    else $error("config pins do not follow bits 6 to 4");

  // Interrupt follows enabled status
  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    |(irq_stat_r & irq_en_r) |=> irq)
    else $error("interrupt missing for enabled status");

  // Status stays until cleared
  a_irq_stat_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (irq_stat_r[IRQ_RST_RESUME] && !(wr_go && aw_addr_r == OFS_IRQ_CLEAR))
    |=> irq_stat_r[IRQ_RST_RESUME])
    else $error("status bit dropped without a clear");

  // Ready flops mirror the held flags
  a_ready_track: assert property (@(posedge clk_sys) disable iff (rst)
    (s_awready != aw_got_r) && (s_wready != w_got_r) && (s_arready != s_rvalid))
    else $error("bus ready out of step with held state");
endmodule

// >>> bench/usb_phy_model.sv
// Purpose: Behavioural PHY partner, line state source and pin sink
// Assumes: Line state is registered once, as a PHY synchroniser would
// Notes:   Pins are captured each clock so the bench sees what reached the PHY
module usb_phy_model
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic       clk_sys,         // System clock
  input  wire logic       rst,             // Async reset, active high
  input  wire logic [1:0] line_cmd,        // Line state asked for by the bench
  input  wire logic       pd_off_8a,       // Pulldown off, port 8A
  input  wire logic       pd_off_8b,       // Pulldown off, port 8B
  input  wire logic [2:0] phy_config_pins, // Configuration pins
  output logic [1:0]      utmi_linestate,  // Line state towards the block
  output logic [1:0]      pd_on,           // Pulldowns active, 8B then 8A
  output logic [2:0]      cfg_seen         // Configuration as captured
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus shows J, so leaving reset is not itself a line event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      utmi_linestate <= LS_J;
    end else begin
      utmi_linestate <= line_cmd;
    end
  end

  always_ff @(posedge clk_sys) begin
    pd_on    <= {~pd_off_8b, ~pd_off_8a};
    cfg_seen <= phy_config_pins;
  end
endmodule

// >>> bench/test_usb_ep_phy_ctrl.sv
// Purpose: Self-checking bench for the endpoint mark and PHY control block
// Assumes: AXI4-Lite master tasks, one clock at 20 MHz
// Notes:   Filter timing is judged through the change interrupt
module test_usb_ep_phy_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import usb_phy_ctrl_pkg::*;

  logic clk_sys, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, suspended, resume_req, pd_off_8a, pd_off_8b, irq;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, otg_mask_out, rd;
  logic [3:0]  s_wstrb, rx_ep_in;
  logic [1:0]  s_bresp, s_rresp, utmi_linestate, line_cmd, pd_on, rsp;
  logic [4:0]  rx_ep_out;
  logic [2:0]  phy_config_pins, cfg_seen;
  logic [8:0]  pwr_word_out;
  int          res_cnt;
  int          num_errors, checks_done, n;

  usb_ep_phy_ctrl dut (.clk_sys(clk_sys), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .rx_ep_in(rx_ep_in),
    .rx_ep_out(rx_ep_out), .utmi_linestate(utmi_linestate), .suspended(suspended),
    .resume_req(resume_req), .pd_off_8a(pd_off_8a), .pd_off_8b(pd_off_8b),
    .phy_config_pins(phy_config_pins), .otg_mask_out(otg_mask_out),
    .pwr_word_out(pwr_word_out), .irq(irq));
  usb_phy_model phy (.clk_sys(clk_sys), .rst(rst), .line_cmd(line_cmd), .pd_off_8a(pd_off_8a),
    .pd_off_8b(pd_off_8b), .phy_config_pins(phy_config_pins),
    .utmi_linestate(utmi_linestate), .pd_on(pd_on), .cfg_seen(cfg_seen));

  // Clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Resume pulses are short, so count them as they pass
  always @(posedge clk_sys or posedge rst) begin
    if (rst) res_cnt <= 0;
    else if (resume_req === 1'b1) res_cnt <= res_cnt + 1;
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    num_errors++;
    $display("mismatch at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    print_verdict();
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    s_awaddr <= a; s_wdata <= d; s_wstrb <= 4'hf;
    s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_awvalid && s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready === 1'b1) s_wvalid <= 1'b0;
      if (++k > 100) give_up();
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clk_sys);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
      if (++k > 100) give_up();
    end while (s_rvalid !== 1'b1);
    d = s_rdata; r = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a, rd, rsp);
    chk(rd, exp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // Counts cycles until the interrupt line rises, with a bound
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim) begin
      @(posedge clk_sys);
      cnt++;
    end
  endtask

  task automatic t_reset();
    rchk(OFS_EP_MARK, 32'h0);
    rchk(OFS_OTG_MASK, 32'h0);
    rchk(OFS_PWR_WORD, 32'h0);
    rchk(OFS_PHY_CTRL, 32'h0);
    chk({23'h0, pwr_word_out}, 32'h0);
    rdr(8'h60, rd, rsp);
    chk({rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h60, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_masks();
    wr(OFS_EP_MARK, 32'hffff_ffff);
    rchk(OFS_EP_MARK, 32'h0000_ffff);
    wr(OFS_OTG_MASK, 32'hdead_beef);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rchk(OFS_OTG_MASK, 32'hdead_beef);
    chk(otg_mask_out, 32'hdead_beef);
    wr(OFS_PWR_WORD, 32'hffff_ffff);
    chk({23'h0, pwr_word_out}, 32'h1ff);
    wr(OFS_PHY_CTRL, 32'hffff_cfff);
    rchk(OFS_PHY_CTRL, 32'h0004_0ff0);
    for (int v = 0; v < 8; v++) begin
      wr(OFS_PHY_CTRL, (32'(v) << CONF_LO) | (32'(v & 1) << BIT_PD_DIS));
      repeat (3) @(posedge clk_sys);
      chk({29'h0, cfg_seen}, 32'(v));
      chk({30'h0, pd_on}, (v & 1) ? 32'h0 : 32'h3);
    end
  endtask

  task automatic t_ep();
    wr(OFS_EP_MARK, 32'h0000_a5c3);
    for (int i = 0; i < NUM_EP; i++) begin
      @(posedge clk_sys);
      rx_ep_in <= 4'(i);
      repeat (2) @(posedge clk_sys);
      chk({27'h0, rx_ep_out}, 32'(i) | ((32'ha5c3 >> i) & 1 ? 32'h10 : 32'h0));
    end
  endtask

  task automatic t_filter();
    wr(OFS_PHY_CTRL, 32'h0000_0300);
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h1);
    @(posedge clk_sys);
    line_cmd <= LS_K;
    wait_irq(40, n);
    chk(32'(n >= 8 && n <= 14), 32'h1);
    rchk(OFS_LINE_STATUS, {30'h0, LS_K});
    wr(OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk_sys);
    line_cmd <= LS_J;
    repeat (4) @(posedge clk_sys);
    line_cmd <= LS_K;
    wait_irq(30, n);
    chk({31'h0, irq}, 32'h0);
    rchk(OFS_LINE_STATUS, {30'h0, LS_K});
    wr(OFS_PHY_CTRL, 32'h0);
    @(posedge clk_sys);
    line_cmd <= LS_J;
    wait_irq(40, n);
    chk(32'(n >= 1 && n <= 7), 32'h1);
  endtask

  task automatic t_resume();
    int base;
    base = res_cnt;
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h6);
    wr(OFS_PHY_CTRL, 32'h80);
    suspended <= 1'b1;
    line_cmd <= LS_SE0;
    wait_irq(40, n);
    chk(32'(res_cnt - base), 32'h1);
    rchk(OFS_PHY_CTRL, 32'h2080);
    rchk(OFS_IRQ_STATUS, 32'h3);
    repeat (20) @(posedge clk_sys);
    rchk(OFS_PHY_CTRL, 32'h2080);
    wr(OFS_PHY_CTRL, 32'h80);
    wr(OFS_IRQ_CLEAR, 32'h2);
    rchk(OFS_PHY_CTRL, 32'h80);
    chk({31'h0, irq}, 32'h0);
    line_cmd <= LS_K;
    wait_irq(40, n);
    chk(32'(res_cnt - base), 32'h2);
    rchk(OFS_PHY_CTRL, 32'h1080);
    rchk(OFS_IRQ_STATUS, 32'h5);
    wr(OFS_PHY_CTRL, 32'h0);
    rchk(OFS_PHY_CTRL, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h7);
    line_cmd <= LS_SE0;
    repeat (20) @(posedge clk_sys);
    chk(32'(res_cnt - base), 32'h2);
    rchk(OFS_PHY_CTRL, 32'h0);
    rchk(OFS_LINE_STATUS, {30'h0, LS_SE0});
  endtask

  // Main sequence
  initial begin
    num_errors = 0; checks_done = 0;
    rst = 1'b1; s_awaddr = 8'h0; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'h0;
    s_wvalid = 1'b0; s_bready = 1'b0; s_araddr = 8'h0; s_arvalid = 1'b0; s_rready = 1'b0;
    rx_ep_in = 4'h0; suspended = 1'b0; line_cmd = LS_J;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_ep();
    t_filter();
    t_resume();
    print_verdict();
  end
endmodule
